// [sar_adc_sequencer.sv]
// apb register file and conversion sequencer of the 10-bit sar converter
`timescale 1ns/1ns
module sar_adc_sequencer
    import sar_adc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic standby_i,          // chip in stop, slow or sleep
    input wire logic comp_i,             // comparator output
    output logic [RES_W-1:0] dac_code_o, // trial code to the ladder
    output logic [3:0] channel_select_o, // analog input mux
    output logic analog_input_disable_o, // analog inputs off
    output logic sample_o,               // sample-hold tracking
    output logic ladder_on_o,            // ladder connected
    output logic ref_voltage_on_o,       // reference voltage connected
    output logic conv_busy_flag_o,       // conversion running
    output logic conv_done_flag_o,       // result waiting
    output logic conv_done_irq_o         // one-cycle interrupt request
);
    // ****************************************************
    // checks and local types
    // ****************************************************
    if (ADDR_W < IDX_LSB + 8) $error("apb address too narrow");

    typedef enum logic {IDLE, CONVERT} seq_state_type;

    // ****************************************************
    // state
    // ****************************************************
    seq_state_type state_r;            // sequencer state
    ctrl_one_type ctrl1_r;             // adc_control_one
    ctrl_two_type ctrl2_r;             // adc_control_two
    logic [RES_W-1:0] res_r;           // stored result
    logic done_flag_r;                 // conv_done_flag
    logic irq_r;                       // conv_done_irq pulse
    logic [RES_W-1:0] sar_code;        // approximation in progress
    logic tmr_step;                    // trial step pulse
    logic tmr_sample;                  // sample phase
    logic tmr_done;                    // final cycle of a conversion

    // ****************************************************
    // apb decode
    // ****************************************************
    // decoded register index, unaligned addresses miss every register
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[IDX_LSB-1:0] == '0) && (a[ADDR_W-1:IDX_LSB] == (ADDR_W-IDX_LSB)'(idx));
    endfunction

    wire access = psel_i && penable_i;
    wire wr_en = access && pwrite_i;
    wire rd_en = access && !pwrite_i;
    wire sel_one = hit(paddr_i, IDX_CONTROL_ONE);
    wire sel_two = hit(paddr_i, IDX_CONTROL_TWO);
    wire sel_high = hit(paddr_i, IDX_RESULT_HIGH);
    wire sel_low = hit(paddr_i, IDX_RESULT_LOW);
    wire mapped = sel_one || sel_two || sel_high || sel_low;
    wire wr_one = wr_en && sel_one && !standby_i;
    wire wr_two = wr_en && sel_two && !standby_i;
    wire rd_high = rd_en && sel_high;
    wire ctrl_one_type wdata_one = ctrl_one_type'(pwdata_i[REG_W-1:0]);
    wire ctrl_two_type wdata_two = ctrl_two_type'(pwdata_i[REG_W-1:0]);

    // zero wait states, error only on unmapped addresses
    assign pready_o = 1'b1;
    assign pslverr_o = access && !mapped;

    // ****************************************************
    // sequencing decisions
    // ****************************************************
    wire busy = (state_r == CONVERT);
    wire new_run_mode = (wdata_one.mode == MODE_SOFT) || (wdata_one.mode == MODE_REPEAT);
    wire chan_ok = (wdata_one.chan <= CHAN_LAST);
    wire [CNT_W-1:0] total = conv_cycles(ctrl2_r.time_sel);
    wire time_ok = (total != CYC_NONE);
    // start only from idle with a valid mode, channel and time
    wire start_go = wr_one && wdata_one.start && new_run_mode && chan_ok
                    && time_ok && !busy;
    // disable write or standby ends a running conversion
    wire abort_go = busy && (standby_i || (wr_one && !new_run_mode));
    wire done_go = busy && tmr_done && !abort_go;
    wire repeat_go = done_go && (ctrl1_r.mode == MODE_REPEAT);
    wire tmr_load = start_go || repeat_go;

    // ****************************************************
    // datapath helpers
    // ****************************************************
    conv_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(tmr_load),
        .abort_i(abort_go),
        .total_i(total),
        .step_o(tmr_step),
        .sample_o(tmr_sample),
        .done_o(tmr_done)
    );

    sar_step_register #(.W(RES_W)) u_sar (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .init_i(tmr_load),
        .step_i(tmr_step && busy),
        .comp_i(comp_i),
        .code_o(sar_code)
    );

    // ****************************************************
    // state machine
    // ****************************************************
    seq_state_type state_nxt;
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            IDLE:
                if (start_go)
                    state_nxt = CONVERT;
            CONVERT:
                if (abort_go || (done_go && !repeat_go))
                    state_nxt = IDLE;
            default:
                state_nxt = IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state_r <= IDLE;
        else
            state_r <= state_nxt;
    end

    // ****************************************************
    // control registers
    // ****************************************************
    // start bit never stored, so it reads zero once taken
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ctrl1_r <= CTRL_ONE_RESET;
        else if (standby_i)
            ctrl1_r <= CTRL_ONE_RESET;
        else if (wr_one)
            ctrl1_r <= {1'b0, wdata_one.mode, wdata_one.ain_dis, wdata_one.chan};
    end

    // time select and ladder control
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ctrl2_r <= CTRL_TWO_RESET;
        else if (standby_i)
            ctrl2_r <= CTRL_TWO_RESET;
        else if (wr_two)
            ctrl2_r <= wdata_two;
    end

    // ****************************************************
    // result, flag and interrupt
    // ****************************************************
    // result changes only on completion, cleared by standby
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            res_r <= RESULT_RESET;
        else if (standby_i)
            res_r <= RESULT_RESET;
        else if (done_go)
            res_r <= sar_code;
    end

    // completion sets, high read or a new start clears, set wins
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            done_flag_r <= 1'b0;
        else if (done_go)
            done_flag_r <= 1'b1;
        else if (standby_i || rd_high || start_go)
            done_flag_r <= 1'b0;
    end

    // interrupt pulse on the edge that sets the flag
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_r <= 1'b0;
        else
            irq_r <= done_go;
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign conv_done_irq_o = irq_r;
    assign conv_done_flag_o = done_flag_r;
    assign conv_busy_flag_o = busy;
    assign dac_code_o = sar_code;
    assign channel_select_o = ctrl1_r.chan;
    assign analog_input_disable_o = ctrl1_r.ain_dis;
    assign sample_o = busy && tmr_sample;
    assign ladder_on_o = !standby_i && (ctrl2_r.ladder || busy);
    assign ref_voltage_on_o = !standby_i;

    // read data, unread bits zero
    wire [REG_W-1:0] low_status = {res_r[1:0], done_flag_r, busy, UNSTABLE_BITS};
    wire [REG_W-1:0] ctrl2_view = {2'h0, ctrl2_r.ladder, ctrl2_r.fixed_one,
                                   ctrl2_r.time_sel, ctrl2_r.fixed_zero};
    wire [REG_W-1:0] rd_byte = sel_one ? ctrl1_r :
                               sel_two ? ctrl2_view :
                               sel_high ? res_r[RES_W-1:2] :
                               sel_low ? low_status : '0;
    assign prdata_o = rd_en ? DATA_W'(rd_byte) : '0;

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // cycles since the conversion began
    logic [CNT_W-1:0] len_r;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            len_r <= '0;
        else if (tmr_load)
            len_r <= '0;
        else if (busy)
            len_r <= len_r + 1'b1;
    end

    a_start_busy: assert property (start_go |=> busy && !ctrl1_r.start)
        else $error("start did not begin conversion");
    a_start_self_clear: assert property (wr_one |=> ctrl1_r.start == 1'b0)
        else $error("start bit stayed set");
    a_done_store: assert property (done_go |=> irq_r && done_flag_r
        && res_r == $past(sar_code))
        else $error("completion effects not together");
    a_conv_length: assert property (done_go |-> len_r == total - 1'b1)
        else $error("conversion length wrong");
    a_repeat_restart: assert property (repeat_go |=> busy && len_r == '0)
        else $error("repeat mode did not restart");
    a_abort_discard: assert property (abort_go && !standby_i |=> !busy
        && res_r == $past(res_r) && !irq_r)
        else $error("aborted value stored");
    a_flag_read_clear: assert property (rd_high && !done_go |=> !done_flag_r)
        else $error("high read kept done flag");
    a_restart_keeps: assert property (start_go |=> !done_flag_r
        && $stable(res_r))
        else $error("restart lost flag rule or result");
    a_standby_init: assert property (standby_i |=> !busy && res_r == RESULT_RESET
        && ctrl1_r == CTRL_ONE_RESET && ctrl2_r == CTRL_TWO_RESET)
        else $error("standby did not initialise");
    a_ladder_idle: assert property (!busy && !ctrl2_r.ladder |-> !ladder_on_o)
        else $error("ladder connected while idle");
    a_irq_single: assert property (irq_r |=> !irq_r)
        else $error("interrupt longer than one cycle");

    // trial steps taken this conversion
    logic [3:0] steps_r;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            steps_r <= '0;
        else if (tmr_load)
            steps_r <= '0;
        else if (tmr_step && busy)
            steps_r <= steps_r + 1'b1;
    end

    // all ten bits decided before completion
    a_sar_steps: assert property (done_go |-> steps_r == 4'(STEP_COUNT))
        else $error("wrong number of trial steps");
    // refused start leaves the block idle
    a_bad_start: assert property (wr_one && wdata_one.start && !busy
        && !(new_run_mode && chan_ok && time_ok) |=> !busy)
        else $error("refused start began a conversion");
    // no conversion without a start write
    a_no_resume: assert property (!busy && !start_go |=> !busy)
        else $error("conversion began without a start");
    // standby cuts ladder and reference
    a_standby_off: assert property (standby_i |-> !ladder_on_o && !ref_voltage_on_o)
        else $error("ladder or reference on in standby");
    // result moves only on completion or standby
    a_result_hold: assert property (!done_go && !standby_i |=> $stable(res_r))
        else $error("result changed without completion");
    // flag stays until read, restart or standby
    a_flag_stands: assert property (done_flag_r && !rd_high && !start_go && !standby_i
        |=> done_flag_r)
        else $error("done flag dropped on its own");
    // interrupt only with the flag
    a_irq_with_flag: assert property (irq_r |-> done_flag_r)
        else $error("interrupt without done flag");
    // low register shows result bits and flags
    a_low_status: assert property (rd_en && sel_low |-> prdata_o[7:4]
        == {res_r[1:0], done_flag_r, busy})
        else $error("low status read wrong");

    // ****************************************************
    // cover points
    // ****************************************************
    c_refused_start: cover property (wr_one && wdata_one.start && !busy && !start_go);
    c_soft_done: cover property (start_go ##[1:1000] (irq_r && ctrl1_r.mode == MODE_SOFT));
    c_repeat_twice: cover property (repeat_go ##[1:1000] repeat_go);
    c_abort_run: cover property (busy ##1 abort_go);
    c_standby_run: cover property (busy && standby_i);
endmodule

// [sar_adc_pkg.sv]
// register map, field layouts and timing constants of the converter sequencer
package sar_adc_pkg;

    // ****************************************************
    // widths
    // ****************************************************
    localparam int DATA_W = 32;        // apb data width
    localparam int REG_W = 8;          // width of every register
    localparam int RES_W = 10;         // conversion result width
    localparam int CNT_W = 11;         // conversion cycle counter width
    localparam int STEP_COUNT = 10;    // one trial step per result bit
    localparam int STEP_SHIFT = 4;     // trial step period is the total over sixteen
    localparam int IDX_LSB = 2;        // byte address to register index shift

    // ****************************************************
    // register indices, byte address is four times the index
    // ****************************************************
    localparam logic [7:0] IDX_CONTROL_ONE = 8'h1e;
    localparam logic [7:0] IDX_CONTROL_TWO = 8'h1f;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h20;
    localparam logic [7:0] IDX_RESULT_LOW = 8'h21;

    // ****************************************************
    // field layouts
    // ****************************************************
    typedef struct packed {
        logic start;           // conv_start_bit
        logic [1:0] mode;      // op_mode_field
        logic ain_dis;         // analog_input_disable
        logic [3:0] chan;      // channel_select
    } ctrl_one_type;

    typedef struct packed {
        logic [1:0] undef;     // reads as zero
        logic ladder;          // ladder_connect
        logic fixed_one;       // kept as written
        logic [2:0] time_sel;  // conversion time select
        logic fixed_zero;      // kept as written
    } ctrl_two_type;

    localparam ctrl_one_type CTRL_ONE_RESET = ctrl_one_type'(8'h00);
    localparam ctrl_two_type CTRL_TWO_RESET = ctrl_two_type'(8'h00);
    localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [3:0] UNSTABLE_BITS = 4'h0;   // low status bits read as zero

    // ****************************************************
    // mode and channel codes
    // ****************************************************
    localparam logic [1:0] MODE_DISABLE = 2'h0;
    localparam logic [1:0] MODE_SOFT = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h3;
    localparam logic [3:0] CHAN_LAST = 4'h7;

    // ****************************************************
    // conversion time in fc periods
    // ****************************************************
    localparam logic [CNT_W-1:0] CYC_T2 = 11'd78;
    localparam logic [CNT_W-1:0] CYC_T3 = 11'd156;
    localparam logic [CNT_W-1:0] CYC_T4 = 11'd312;
    localparam logic [CNT_W-1:0] CYC_T5 = 11'd624;
    localparam logic [CNT_W-1:0] CYC_T6 = 11'd1248;
    localparam logic [CNT_W-1:0] CYC_NONE = 11'd0;

    // time select code to cycle count, zero for reserved codes
    function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] sel);
        case (sel)
            3'h2: conv_cycles = CYC_T2;
            3'h3: conv_cycles = CYC_T3;
            3'h4: conv_cycles = CYC_T4;
            3'h5: conv_cycles = CYC_T5;
            3'h6: conv_cycles = CYC_T6;
            default: conv_cycles = CYC_NONE;
        endcase
    endfunction

endpackage

// [sar_step_register.sv]
// successive-approximation register, one trial bit per step
`timescale 1ns/1ns
module sar_step_register
    import sar_adc_pkg::*;
#(
    parameter int W = RES_W
)
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic init_i,        // begin a new approximation
    input wire logic step_i,        // decide the current trial bit
    input wire logic comp_i,        // comparator, high keeps the trial bit
    output logic [W-1:0] code_o     // trial code toward the ladder
);
    // ****************************************************
    // checks and state
    // ****************************************************
    if (W < 2) $error("sar width too small");

    logic [W-1:0] mask_r;           // one-hot trial bit
    localparam logic [W-1:0] TOP_BIT = {1'b1, {(W-1){1'b0}}};

    // keep or drop the trial bit, then try the next lower one
    wire [W-1:0] kept = comp_i ? code_o : (code_o & ~mask_r);
    wire [W-1:0] code_nxt = kept | (mask_r >> 1);

    // register update from msb to lsb
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            code_o <= '0;
            mask_r <= '0;
        end
        else if (init_i)
        begin
            code_o <= TOP_BIT;
            mask_r <= TOP_BIT;
        end
        else if (step_i)
        begin
            code_o <= code_nxt;
            mask_r <= mask_r >> 1;
        end
    end
endmodule

// [conv_timer.sv]
// conversion cycle counter with sample phase and trial step pulses
`timescale 1ns/1ns
module conv_timer
    import sar_adc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,                // start a conversion
    input wire logic abort_i,               // stop at once
    input wire logic [CNT_W-1:0] total_i,   // conversion length in cycles
    output logic step_o,                    // decide one bit
    output logic sample_o,                  // sample-hold phase
    output logic done_o                     // last cycle of the conversion
);
    // ****************************************************
    // counters
    // ****************************************************
    logic run_r;                    // counting
    logic [CNT_W-1:0] cnt_r;        // cycles left
    logic [CNT_W-1:0] next_r;       // count at which the next step falls
    logic [CNT_W-1:0] bp_r;         // step period
    logic [CNT_W-1:0] win_r;        // start of the step window

    wire [CNT_W-1:0] period = total_i >> STEP_SHIFT;
    wire [CNT_W-1:0] window = CNT_W'(STEP_COUNT * period);

    assign done_o = run_r && (cnt_r == '0);
    assign step_o = run_r && (cnt_r == next_r) && (next_r != '0);
    assign sample_o = run_r && (cnt_r > win_r);

    // count down, last step lands one period before the end
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            run_r <= 1'b0;
            cnt_r <= '0;
            next_r <= '0;
            bp_r <= '0;
            win_r <= '0;
        end
        else if (load_i)
        begin
            run_r <= 1'b1;
            cnt_r <= total_i - 1'b1;
            next_r <= window;
            bp_r <= period;
            win_r <= window;
        end
        else if (abort_i || done_o)
            run_r <= 1'b0;
        else if (run_r)
        begin
            cnt_r <= cnt_r - 1'b1;
            if (step_o)
                next_r <= next_r - bp_r;
        end
    end
endmodule

// [sar_analog_model.sv]
// analog side stand-in: channel mux, sample-hold and comparator
`timescale 1ns/1ns
module sar_analog_model
    import sar_adc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic [7:0][RES_W-1:0] level_i,   // input voltage per channel
    input wire logic [3:0] channel_select_i,     // analog input mux
    input wire logic sample_i,                   // sample-hold tracking
    input wire logic ref_voltage_on_i,           // reference connected
    input wire logic [RES_W-1:0] dac_code_i,     // trial code from the ladder
    output logic comp_o                          // high keeps the trial bit
);
    logic [RES_W-1:0] held_r; // held input voltage

    // track the selected input while sampling, hold it afterwards
    always_ff @(posedge sys_clk_i)
    begin
        if (sample_i)
            held_r <= level_i[channel_select_i[2:0]];
    end

    // without reference the comparator never keeps a bit
    assign comp_o = ref_voltage_on_i && (held_r >= dac_code_i);
endmodule

// [tb_sar_adc_sequencer.sv]
// self-checking bench of the converter sequencer
`timescale 1ns/1ns
module tb_sar_adc_sequencer import sar_adc_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h86f3;
    logic pready, pslverr, err, comp, sample, ref_on, ladder_on, busy, done, irq, ain_off;
    logic [RES_W-1:0] dac, old;
    logic [3:0] chan;
    logic [2:0] c;
    logic [7:0][RES_W-1:0] level = '0; // analog input voltages
    int fails = 0, n_checks = 0, cyc = 0, t0 = 0;

    sar_adc_sequencer dut (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .standby_i(standby), .comp_i(comp),
        .dac_code_o(dac), .channel_select_o(chan), .analog_input_disable_o(ain_off),
        .sample_o(sample), .ladder_on_o(ladder_on), .ref_voltage_on_o(ref_on),
        .conv_busy_flag_o(busy), .conv_done_flag_o(done), .conv_done_irq_o(irq));
    sar_analog_model model (.sys_clk_i(clk), .level_i(level), .channel_select_i(chan),
        .sample_i(sample), .ref_voltage_on_i(ref_on), .dac_code_i(dac), .comp_o(comp));

    // ****************************************************
    // clock, cycle count and hang guard
    // ****************************************************
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(negedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end

    // ****************************************************
    // helpers
    // ****************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [11:0] adr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00}; // byte address is four times the index
    endfunction
    // expected low result and status byte
    function automatic logic [31:0] low_exp(input logic [RES_W-1:0] lv, input logic d, b);
        return {24'h0, lv[1:0], d, b, 4'h0};
    endfunction
    // one apb transfer, released only after pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // program time, then write mode and channel together with the start bit
    task automatic run(input logic [1:0] mode, input logic [2:0] t, input logic [2:0] ch);
        apb(1'b1, adr(IDX_CONTROL_TWO), {4'b0001, t, 1'b0});
        apb(1'b1, adr(IDX_CONTROL_ONE), {1'b1, mode, 2'b00, ch});
        t0 = cyc;
    endtask
    // wait for the interrupt and check the elapsed cycles
    task automatic wait_irq(input int n);
        int i;
        i = 0;
        do
        begin
            @(posedge clk);
            #1;
            i++;
        end
        while (irq !== 1'b1 && i < 2000);
        check(cyc - t0, n);
        t0 = cyc;
    endtask
    task automatic read_result(input logic [RES_W-1:0] lv);
        apb(1'b0, adr(IDX_RESULT_LOW), 8'h00);
        check(rd, low_exp(lv, 1'b1, 1'b0));
        apb(1'b0, adr(IDX_RESULT_HIGH), 8'h00);
        check(rd, {24'h0, lv[9:2]});
        apb(1'b0, adr(IDX_RESULT_LOW), 8'h00);
        check(rd, low_exp(lv, 1'b0, 1'b0));
    endtask
    task automatic zero_regs();
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b0, adr(8'(IDX_CONTROL_ONE + k)), 8'h00);
            check(rd, 32'h0);
        end
    endtask

    // ****************************************************
    // main sequence
    // ****************************************************
    initial
    begin
        for (int k = 0; k < 8; k++)
            level[k] = RES_W'(rnd());
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        zero_regs();
        check(err, 1'b0);
        apb(1'b0, 12'h000, 8'h00);
        check(err, 1'b1);
        // every legal time code once, soft start
        for (int t = 2; t <= 6; t++)
        begin
            c = 3'(rnd());
            run(MODE_SOFT, 3'(t), c);
            apb(1'b0, adr(IDX_CONTROL_ONE), 8'h00);
            check(rd, {24'h0, 1'b0, MODE_SOFT, 2'b00, c});
            check({busy, ladder_on}, 2'b11);
            wait_irq(78 << (t - 2));
            check({done, busy, irq}, 3'b101);
            @(posedge clk);
            #1;
            check(irq, 1'b0);
            read_result(level[c]);
        end
        // restart before reading keeps the old result
        run(MODE_SOFT, 3'h2, 3'h0);
        wait_irq(78);
        old = level[0];
        level[0] = ~old;
        run(MODE_SOFT, 3'h2, 3'h0);
        apb(1'b0, adr(IDX_RESULT_LOW), 8'h00);
        check(rd, low_exp(old, 1'b0, 1'b1));
        wait_irq(78);
        read_result(level[0]);
        // repeat mode, then abort mid conversion
        run(MODE_REPEAT, 3'h2, 3'h1);
        wait_irq(78);
        wait_irq(78);
        old = level[1];
        level[1] = ~old;
        check(busy, 1'b1);
        repeat (20) @(posedge clk);
        apb(1'b1, adr(IDX_CONTROL_ONE), {1'b0, MODE_DISABLE, 5'h11});
        apb(1'b0, adr(IDX_RESULT_LOW), 8'h00);
        check(rd, low_exp(old, 1'b1, 1'b0));
        check({ain_off, chan}, 5'h11);
        // refused starts: mode 10, channel 8, reserved time; ladder held on
        apb(1'b1, adr(IDX_CONTROL_ONE), 8'hc0);
        apb(1'b1, adr(IDX_CONTROL_ONE), 8'ha8);
        apb(1'b1, adr(IDX_CONTROL_TWO), 8'h30);
        apb(1'b1, adr(IDX_CONTROL_ONE), 8'ha0);
        apb(1'b0, adr(IDX_CONTROL_TWO), 8'h00);
        check(rd, 32'h30);
        check({busy, ladder_on}, 2'b01);
        // standby aborts and clears, writes ignored, no resume
        run(MODE_SOFT, 3'h6, 3'h2);
        repeat (50) @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        #1;
        check({busy, ref_on, ladder_on}, 3'b000);
        apb(1'b1, adr(IDX_CONTROL_TWO), 8'h3c);
        zero_regs();
        standby <= 1'b0;
        repeat (1300) @(posedge clk);
        #1;
        check({busy, done, ref_on}, 3'b001);
        print_verdict();
    end
endmodule
